// ### core/adc_access_pkg.sv
// Shared constants for the converter register access link and its controller.
// Assumes one clock domain at 200 MHz.
package adc_access_pkg;
    localparam int          CLK_MHZ         = 200;
    localparam int          SETUP_NS        = 1000;
    localparam int          SETUP_CYC       = (SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int          ADDR_W          = 3;
    localparam int          CONV_CYC        = 16;
    // Device register addresses on the link
    localparam logic [2:0]  DEV_MODE        = 3'h0;
    localparam logic [2:0]  DEV_CHSEL       = 3'h1;
    localparam logic [2:0]  DEV_PORTCFG     = 3'h2;
    localparam logic [2:0]  DEV_RESULT_HI   = 3'h3;
    localparam logic [2:0]  DEV_STATUS      = 3'h4;
    // Mode register fields, channel select mask and register reset value
    localparam int          MODE_START_BIT  = 7;
    localparam int          MODE_ENABLE_BIT = 0;
    localparam logic [7:0]  CHSEL_MASK      = 8'h07;
    localparam logic [7:0]  RESET_VAL       = 8'h00;
    // Controller registers on the software port
    localparam logic [3:0]  CTL_CMD         = 4'h0;
    localparam logic [3:0]  CTL_CHAN        = 4'h1;
    localparam logic [3:0]  CTL_PORTCFG     = 4'h2;
    localparam logic [3:0]  CTL_RESULT      = 4'h3;
    localparam logic [3:0]  CTL_STATUS      = 4'h4;
    localparam logic [3:0]  CTL_IRQ_STAT    = 4'h5;
    localparam logic [3:0]  CTL_IRQ_EN      = 4'h6;
    localparam logic [3:0]  CTL_IRQ_CLR     = 4'h7;
    localparam logic [3:0]  CTL_PORT2_DIR   = 4'h8;
    // Command bits
    localparam int          CMD_POWER_BIT   = 0;
    localparam int          CMD_SKIP_BIT    = 1;
    localparam int          CMD_STOP_BIT    = 2;
    // Controller interrupt bits
    localparam int          IRQ_RESULT_BIT  = 0;
    localparam int          IRQ_ERROR_BIT   = 1;
    typedef enum logic [2:0] {
        C_IDLE    = 3'b000,
        C_SETUP   = 3'b001,
        C_START   = 3'b010,
        C_WAIT    = 3'b011,
        C_READ    = 3'b100,
        C_BUSY    = 3'b101
    } ctl_state_t;
endpackage : adc_access_pkg

// ### core/adc_link_if.sv
// Register link between converter block and its bus controller.
// Assumes both ends share clk.
`timescale 1ns/1ps
`default_nettype none
interface adc_link_if;
    logic        req;
    logic        wr;
    logic [2:0]  addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        ack;
    logic        pclk_run;
    logic        done_irq;
    modport dev  (input req, wr, addr, wdata, output rdata, ack, pclk_run, done_irq);
    modport ctrl (output req, wr, addr, wdata, input rdata, ack, pclk_run, done_irq);
endinterface : adc_link_if
`default_nettype wire

// ### core/adc_device.sv
// Converter register block: mode, channel select, port config, result high byte.
// Assumes a link master that holds req until ack.
`timescale 1ns/1ps
`default_nettype none
module adc_device
    import adc_access_pkg::*;
#(
    parameter int CONV_CYCLES = CONV_CYC
) (
    // Clock and reset
    input  wire logic   clk,
    input  wire logic   nrst,
    // Link
    adc_link_if.dev     link,
    // Analog side
    input  wire logic [7:0] sample_value,
    input  wire logic       pclk_enable
);
    logic [7:0]  mode_ff, chsel_ff, portcfg_ff, result_ff;
    logic [7:0]  conv_cnt_ff;
    logic        wait_ff, ack_ff, irq_ff, undef_ff;
    logic [7:0]  rdata_ff;

    wire sel_mode    = link.addr == DEV_MODE;
    wire sel_chsel   = link.addr == DEV_CHSEL;
    wire sel_portcfg = link.addr == DEV_PORTCFG;
    wire sel_result  = link.addr == DEV_RESULT_HI;
    wire cfg_write   = link.req && link.wr && (sel_mode || sel_chsel || sel_portcfg);
    wire needs_wait  = link.req && ((link.wr && (sel_chsel || sel_portcfg))
                                   || (!link.wr && sel_result)); // [R3] [R6] [R8]
    wire running     = mode_ff[MODE_START_BIT] && mode_ff[MODE_ENABLE_BIT];
    wire conv_end    = running && (conv_cnt_ff == 8'(CONV_CYCLES - 1));
    wire do_access   = link.req && !ack_ff && (!needs_wait || wait_ff) && pclk_enable; // [R15]
    wire [7:0] status_v = {5'h00, undef_ff, irq_ff, running};
    wire [7:0] rd_mux   = sel_mode    ? mode_ff    :
                          sel_chsel   ? chsel_ff   :
                          sel_portcfg ? portcfg_ff :
                          sel_result  ? result_ff  :
                          (link.addr == DEV_STATUS) ? status_v : 8'h00;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            mode_ff     <= RESET_VAL;
            chsel_ff    <= RESET_VAL;
            portcfg_ff  <= RESET_VAL;
            result_ff   <= RESET_VAL;
            conv_cnt_ff <= 8'h00;
            wait_ff     <= 1'b0;
            ack_ff      <= 1'b0;
            irq_ff      <= 1'b0;
            undef_ff    <= 1'b0;
            rdata_ff    <= 8'h00;
        end else begin
            wait_ff  <= needs_wait && !wait_ff && !ack_ff && pclk_enable; // [R3] [R6] [R8]
            ack_ff   <= do_access;
            irq_ff   <= conv_end && !(do_access && cfg_write); // [R14]
            if (do_access && !link.wr) begin
                rdata_ff <= rd_mux;
            end
            if (do_access && cfg_write) begin
                if (sel_mode) mode_ff <= link.wdata;
                if (sel_chsel) chsel_ff <= link.wdata & CHSEL_MASK;
                if (sel_portcfg) portcfg_ff <= link.wdata;
                conv_cnt_ff <= 8'h00;
                undef_ff    <= 1'b1; // [R1]
            end else if (conv_end) begin
                result_ff   <= sample_value; // [R14]
                conv_cnt_ff <= 8'h00;
                undef_ff    <= 1'b0;
            end else if (running) begin
                conv_cnt_ff <= conv_cnt_ff + 8'h01;
            end
        end
    end

    assign link.rdata    = rdata_ff;
    assign link.ack      = ack_ff;
    assign link.pclk_run = pclk_enable;
    assign link.done_irq = irq_ff;
endmodule : adc_device
`default_nettype wire

// ### core/adc_controller.sv
// Bus-side controller: sequences converter start-up and result reads.
// Assumes software on a plain strobe port, read data one cycle later.
//
// Behaviour
// R1: Config writes may corrupt result high byte
// R2: Read result after completion, before reconfiguring
// R3: Result high byte reads insert wait cycle
// R4: No result read with peripheral clock stopped
// R5: Channel select bits 3..7 written zero
// R6: Channel select writes insert wait cycle
// R7: No channel write with peripheral clock stopped
// R8: Port config writes insert wait cycle
// R9: No port config write, peripheral clock stopped
// R10: Conversion pins set input via port2 direction
// R11: Power-up to start at least 1 us
// R12: Power-up may occur between steps 2, 4
// R13: Skipped power-up: discard first conversion result
// R14: Config write at conversion end wins
// R15: Wait holds bus until access completes
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module adc_controller
    import adc_access_pkg::*;
#(
    parameter int SETUP_CYCLES = SETUP_CYC
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // Software port
    input  wire logic [3:0]  sw_addr,
    input  wire logic [7:0]  sw_wdata,
    input  wire logic        sw_wr,
    input  wire logic        sw_rd,
    output logic [7:0]       sw_rdata,
    output logic             irq,
    // Port 2 direction
    output logic [7:0]       port2_direction_reg,
    // Link
    adc_link_if.ctrl         link
);
    ctl_state_t  state_ff, nxt_state;
    logic [7:0]  cmd_ff, chan_ff, pcfg_ff, dir_ff, result_ff, rdata_ff;
    logic [1:0]  irq_stat_ff, irq_en_ff;
    logic [15:0] setup_cnt_ff;
    logic        discard_ff, err_ff, stop_ff;
    logic        req_v, wr_v;
    logic [2:0]  addr_v;
    logic [7:0]  wdata_v;

    // Software port decode
    wire sel_cmd     = sw_addr == CTL_CMD;
    wire sel_chan    = sw_addr == CTL_CHAN;
    wire sel_pcfg    = sw_addr == CTL_PORTCFG;
    wire sel_result  = sw_addr == CTL_RESULT;
    wire sel_status  = sw_addr == CTL_STATUS;
    wire sel_istat   = sw_addr == CTL_IRQ_STAT;
    wire sel_ien     = sw_addr == CTL_IRQ_EN;
    wire sel_iclr    = sw_addr == CTL_IRQ_CLR;
    wire sel_dir     = sw_addr == CTL_PORT2_DIR;
    wire wr_cmd      = sw_wr && sel_cmd;
    wire wr_chan     = sw_wr && sel_chan;
    wire wr_pcfg     = sw_wr && sel_pcfg;
    wire wr_ien      = sw_wr && sel_ien;
    wire wr_iclr     = sw_wr && sel_iclr;
    wire wr_dir      = sw_wr && sel_dir;

    // Command and event decode
    wire start_cmd   = wr_cmd && sw_wdata[CMD_POWER_BIT] && !sw_wdata[CMD_STOP_BIT];
    wire stop_cmd    = wr_cmd && sw_wdata[CMD_STOP_BIT];
    wire is_idle     = state_ff == C_IDLE;
    wire pins_in     = (dir_ff & pcfg_ff) == pcfg_ff; // [R10]
    wire setup_ok    = setup_cnt_ff >= 16'(SETUP_CYCLES); // [R11]
    wire done        = req_v && link.ack;
    wire read_done   = done && state_ff == C_READ;
    wire ev_result   = read_done && !discard_ff; // [R13]
    wire ev_error    = start_cmd && (!pins_in || !link.pclk_run); // [R7] [R9] [R10]
    wire go          = start_cmd && pins_in && link.pclk_run;
    wire [1:0] clr_v = wr_iclr ? sw_wdata[1:0] : 2'h0;
    wire [1:0] set_v = {ev_error, ev_result};
    wire [7:0] start_word = 8'((1 << MODE_START_BIT) | (1 << MODE_ENABLE_BIT));
    wire [7:0] status_v   = {4'h0, discard_ff, setup_ok, !is_idle, err_ff};
    wire [7:0] rd_mux     = sel_cmd    ? cmd_ff               :
                            sel_chan   ? chan_ff              :
                            sel_pcfg   ? pcfg_ff              :
                            sel_result ? result_ff            :
                            sel_status ? status_v             :
                            sel_istat  ? {6'h00, irq_stat_ff} :
                            sel_ien    ? {6'h00, irq_en_ff}   :
                            sel_dir    ? dir_ff               : 8'h00;

    // Sequencer: channel, port config, mode start, then, until a stop, a read per done pulse seen with pclk_run high
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            C_IDLE: begin
                if (go) nxt_state = C_SETUP;
            end
            C_SETUP: begin
                if (done) nxt_state = C_BUSY;
            end
            C_BUSY: begin
                if (done) nxt_state = C_START;
            end
            C_START: begin
                if (done) nxt_state = C_WAIT;
            end
            C_WAIT: begin
                if (stop_cmd || stop_ff) nxt_state = C_IDLE;
                else if (link.done_irq && link.pclk_run) nxt_state = C_READ; // [R2] [R4]
            end
            C_READ: begin
                if (done) nxt_state = C_WAIT;
            end
            default: nxt_state = C_IDLE;
        endcase
    end

    // State; a stop seen mid-sequence is kept until the sequencer reaches C_WAIT
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_ff <= C_IDLE;
            stop_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            stop_ff  <= (stop_ff || stop_cmd) && nxt_state != C_IDLE;
        end
    end

    // Software registers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cmd_ff   <= RESET_VAL;
            chan_ff  <= RESET_VAL;
            pcfg_ff  <= RESET_VAL;
            dir_ff   <= 8'hff;
            rdata_ff <= 8'h00;
        end else begin
            if (sw_rd) rdata_ff <= rd_mux;
            if (wr_cmd) cmd_ff <= sw_wdata;
            if (wr_chan) chan_ff <= sw_wdata & CHSEL_MASK; // [R5]
            if (wr_pcfg) pcfg_ff <= sw_wdata;
            if (wr_dir) dir_ff <= sw_wdata; // [R10]
        end
    end

    // Interrupt status and enable; a set beats a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!nrst) begin
            irq_stat_ff <= 2'h0;
            irq_en_ff   <= 2'h0;
            err_ff      <= 1'b0;
        end else begin
            irq_stat_ff <= (irq_stat_ff & ~clr_v) | set_v;
            if (wr_ien) irq_en_ff <= sw_wdata[1:0];
            if (start_cmd) err_ff <= ev_error;
        end
    end

    // Set-up timer and first-result discard
    always_ff @(posedge clk) begin
        if (!nrst) begin
            setup_cnt_ff <= 16'h0000;
            discard_ff   <= 1'b0;
        end else if (is_idle && start_cmd) begin
            setup_cnt_ff <= 16'h0000;
            discard_ff   <= sw_wdata[CMD_SKIP_BIT]; // [R13]
        end else begin
            if (!setup_ok && !is_idle) setup_cnt_ff <= setup_cnt_ff + 16'h0001; // [R11]
            if (read_done) discard_ff <= 1'b0; // [R13]
        end
    end

    // Result capture
    always_ff @(posedge clk) begin
        if (!nrst) begin
            result_ff <= RESET_VAL;
        end else if (ev_result) begin
            result_ff <= link.rdata;
        end
    end

    // Link request issue; held until ack
    always_comb begin
        req_v   = 1'b0;
        wr_v    = 1'b1;
        addr_v  = DEV_MODE;
        wdata_v = 8'h00;
        case (state_ff)
            C_SETUP: begin
                req_v   = 1'b1;
                addr_v  = DEV_CHSEL;
                wdata_v = chan_ff & CHSEL_MASK; // [R5] [R7] [R12]
            end
            C_BUSY: begin
                req_v   = 1'b1;
                addr_v  = DEV_PORTCFG;
                wdata_v = pcfg_ff; // [R8] [R9]
            end
            C_START: begin
                req_v   = setup_ok; // [R11]
                wdata_v = start_word;
            end
            C_READ: begin
                req_v  = 1'b1; // [R15]
                wr_v   = 1'b0;
                addr_v = DEV_RESULT_HI; // [R3]
            end
            default: req_v = 1'b0;
        endcase
    end

    assign link.req            = req_v;
    assign link.wr             = wr_v;
    assign link.addr           = addr_v;
    assign link.wdata          = wdata_v;
    assign sw_rdata            = rdata_ff;
    assign irq                 = |(irq_stat_ff & irq_en_ff);
    assign port2_direction_reg = dir_ff;
endmodule : adc_controller
`default_nettype wire

// ### sim/adc_access_checker.sv
// Assertions on the converter register link.
// Assumes both link ends are design modules on one clock.
`timescale 1ns/1ps
`default_nettype none
module adc_access_checker
    import adc_access_pkg::*;
(
    // Clock and reset
    input wire logic       clk,
    input wire logic       nrst,
    // Link
    input wire logic       req,
    input wire logic       wr,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic       ack,
    input wire logic       pclk_run,
    input wire logic       done_irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    wire hi_rd = !wr && addr == DEV_RESULT_HI;
    wire cs_wr = wr && addr == DEV_CHSEL;
    wire pc_wr = wr && addr == DEV_PORTCFG;
    sequence s_start;
        req && (!$past(req) || $past(ack));
    endsequence
    sequence s_take;
        s_start ##0 pclk_run;
    endsequence
    sequence s_wait_ack;
        !ack ##1 ack;
    endsequence
    a_result_rd_wait: assert property (s_take ##0 hi_rd |=> s_wait_ack)
        else $error("result read without wait cycle");
    a_chsel_wr_wait: assert property (s_take ##0 cs_wr |=> s_wait_ack)
        else $error("channel write without wait cycle");
    a_portcfg_wait: assert property (s_take ##0 pc_wr |=> s_wait_ack)
        else $error("port config write without wait cycle");
    a_mode_ack: assert property (s_take ##0 wr && addr == DEV_MODE |=> ack)
        else $error("mode write ack late");
    a_req_held: assert property (req && !ack |=> req && $stable(addr) && $stable(wdata))
        else $error("request dropped before ack");
    a_ack_one_cycle: assert property (ack |=> !ack)
        else $error("ack longer than one cycle");
    a_no_stopped_req: assert property (s_start ##0 (hi_rd || cs_wr || pc_wr) |-> pclk_run)
        else $error("access with peripheral clock stopped");
    a_stopped_no_ack: assert property (!pclk_run |=> !ack)
        else $error("ack while peripheral clock stopped");
    a_chsel_upper_zero: assert property (req && cs_wr |-> wdata[7:3] == 5'h00)
        else $error("channel upper bits not zero");
    a_cfg_no_irq: assert property (ack && wr && addr <= DEV_PORTCFG |-> !done_irq)
        else $error("done pulse on config write");
endmodule : adc_access_checker
`default_nettype wire

// ### sim/adc_register_access_rules_tb.sv
// Bench: controller and converter joined over the link.
// Assumes the core/ files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module adc_register_access_rules_tb;
    import adc_access_pkg::*;
    logic       clk = 1'b0;
    logic       nrst = 1'b0;
    logic [3:0] sw_addr = 4'h0;
    logic [7:0] sw_wdata = 8'h00;
    logic       sw_wr = 1'b0;
    logic       sw_rd = 1'b0;
    logic [7:0] sw_rdata;
    logic       irq;
    logic [7:0] p2dir;
    logic [7:0] smp = 8'h00;
    logic       pclk_en = 1'b1;
    logic [7:0] d;
    int         n_mismatch = 0;
    int         num_checks = 0;
    int         k;
    int         exp_q [$];
    adc_link_if link ();
    adc_device #(.CONV_CYCLES(16)) adc_device_inst (.clk(clk), .nrst(nrst), .link(link),
        .sample_value(smp), .pclk_enable(pclk_en));
    adc_controller #(.SETUP_CYCLES(4)) adc_controller_inst (.clk(clk), .nrst(nrst),
        .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
        .sw_rdata(sw_rdata), .irq(irq), .port2_direction_reg(p2dir), .link(link));
    adc_access_checker adc_access_checker_inst (.clk(clk), .nrst(nrst), .req(link.req),
        .wr(link.wr), .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata),
        .ack(link.ack), .pclk_run(link.pclk_run), .done_irq(link.done_irq));
    always #2.5 clk = ~clk;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic give_verdict();
        $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict
    task automatic sw_write(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        sw_addr  <= a;
        sw_wdata <= v;
        sw_wr    <= 1'b1;
        @(posedge clk);
        sw_wr    <= 1'b0;
        repeat (6) @(posedge clk);
    endtask : sw_write
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        sw_addr <= a;
        sw_rd   <= 1'b1;
        @(posedge clk);
        sw_rd   <= 1'b0;
        #1 check(sw_rdata, exp);
    endtask : rd
    task automatic wait_irq();
        k = 0;
        while (irq !== 1'b1 && k < 2000) begin
            @(posedge clk);
            k++;
        end
        if (irq !== 1'b1) begin
            n_mismatch++;
            give_verdict();
        end
    endtask : wait_irq
    initial begin
        void'($urandom(32'h4b2d02c4));
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        for (int a = 0; a < 9; a++) rd(4'(a), (a == 8) ? 8'hff : 8'h00);
        $display("Test reset values done");
        d = 8'($urandom);
        sw_write(CTL_CHAN, d);
        sw_write(4'hf, 8'hff);
        rd(CTL_CHAN, d & CHSEL_MASK);
        $display("Test channel select done");
        sw_write(CTL_IRQ_EN, 8'h03);
        sw_write(CTL_PORTCFG, 8'hff);
        for (int n = 0; n < 2; n++) begin
            smp <= 8'($urandom);
            @(posedge clk);
            exp_q.push_back(smp);
            sw_write(CTL_CMD, 8'h00);
            sw_write(CTL_CMD, 8'h01);
            wait_irq();
            rd(CTL_IRQ_STAT, 8'h01);
            rd(CTL_RESULT, 8'(exp_q.pop_front()));
            sw_write(CTL_IRQ_CLR, 8'h01);
            check({7'h00, irq}, 8'h00);
        end
        $display("Test conversion done");
        sw_write(CTL_CMD, 8'h04);
        sw_write(CTL_IRQ_CLR, 8'h03);
        check({7'h00, irq}, 8'h00);
        sw_write(CTL_PORT2_DIR, 8'h00);
        check(p2dir, 8'h00);
        sw_write(CTL_CMD, 8'h01);
        wait_irq();
        rd(CTL_IRQ_STAT, 8'h02);
        sw_write(CTL_PORT2_DIR, 8'hff);
        sw_write(CTL_IRQ_CLR, 8'h03);
        $display("Test start refusal done");
        pclk_en <= 1'b0;
        sw_write(CTL_CMD, 8'h01);
        check({7'h00, link.req}, 8'h00);
        rd(CTL_IRQ_STAT, 8'h02);
        pclk_en <= 1'b1;
        sw_write(CTL_IRQ_CLR, 8'h03);
        $display("Test stopped clock done");
        smp <= 8'($urandom);
        @(posedge clk);
        exp_q.push_back(smp);
        sw_write(CTL_CMD, 8'h03);
        rd(CTL_STATUS, 8'h0e);
        wait_irq();
        rd(CTL_STATUS, 8'h06);
        rd(CTL_RESULT, 8'(exp_q.pop_front()));
        $display("Test skipped setup done");
        give_verdict();
    end
endmodule : adc_register_access_rules_tb
`default_nettype wire
